/* csx_core_status.sv */
// Program status word, auxiliary memory control and external data bus sequencer
// Overview of operation
// - Parity bit 0 is set when the working register has an odd one count.
// - Overflow bit 2 follows signed overflow reported by arithmetic operations.
// - Bits 5 and 1 are plain software flags with no side effect.
// - Bank select bits 4 to 3 choose the active group of eight registers.
// - Bank code n places the registers at byte n times eight.
// - Status register clears on reset, except parity bit 0, which follows the working register.
// - Bit 6 set gives 16-bit external moves, clear gives 8-bit moves.
// - Bit 5 stretches read and write strobes to 15 periods, else 3.
// - Bit 4 set stops the high pointer byte appearing on port two.
// - While suppressed, port two shows its own port register instead.
// - Auxiliary bits 3 to 2 size the on-chip expanded RAM.
// - Sizes 256, 512, 1K, 2K from zero; higher addresses go off-chip.
// - Bit 1 set routes all external moves off-chip, clear uses on-chip RAM within the sized window.
// - Bit 0 set pulses latch strobe only on moves, else every third clock.
// - Auxiliary control resets to x000 1101.
// - Pointer select bit in second auxiliary register picks one of two pointers.
`timescale 1ns/100ps
`include "csx_map.svh"
module csx_core_status (
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              arst_n,
  // Special function register port
  input  wire logic              sfr_wr,
  input  wire logic              sfr_rd,
  input  wire csx_pkg::csx_byte_t sfr_addr,
  input  wire csx_pkg::csx_byte_t sfr_wdata,
  output csx_pkg::csx_byte_t     sfr_rdata,
  // Core datapath status
  input  wire csx_pkg::csx_byte_t main_working_register,
  input  wire logic              ovf_update,
  input  wire logic              ovf_value,
  // External move request
  input  wire logic              move_req,
  input  wire logic              move_write,
  input  wire logic              move_via_pointer,
  input  wire logic [15:0]       move_addr,
  input  wire csx_pkg::csx_byte_t port_two_latch,
  output logic                   move_busy,
  output logic                   move_done,
  // Core configuration outputs
  output logic [4:0]             bank_base,
  output logic                   pointer_select,
  output logic                   onchip_sel,
  output logic                   wide_mode,
  // External bus pins
  output csx_pkg::csx_byte_t     port_two,
  output csx_pkg::csx_byte_t     addr_low,
  output logic                   latch_strobe,
  output logic                   rd_strobe_n,
  output logic                   wr_strobe_n
);
  import csx_pkg::*;

  // Register state
  csx_byte_t program_status_word;
  csx_byte_t next_program_status_word;
  csx_byte_t aux_memory_control;
  csx_byte_t next_aux_memory_control;
  csx_byte_t aux_control_second;
  csx_byte_t next_aux_control_second;
  csx_byte_t next_sfr_rdata;
  logic      parity;

  // Bus sequencer state
  csx_bus_state_t state;
  csx_bus_state_t next_state;
  csx_byte_t      cfg;
  csx_byte_t      next_cfg;
  logic           cyc_write;
  logic           next_cyc_write;
  logic           cyc_ptr;
  logic           next_cyc_ptr;
  logic [15:0]    cyc_addr;
  logic [15:0]    next_cyc_addr;
  logic [1:0]     latch_div;
  logic [1:0]     next_latch_div;
  logic           timer_load;
  logic           timer_expired;
  logic [15:0]    size_limit;
  logic           next_move_busy;
  logic           next_move_done;
  logic [4:0]     next_bank_base;
  logic           next_pointer_select;
  logic           next_onchip_sel;
  logic           next_wide_mode;
  csx_byte_t      next_port_two;
  csx_byte_t      next_addr_low;
  logic           next_latch_strobe;
  logic           next_rd_strobe_n;
  logic           next_wr_strobe_n;

  csx_strobe_timer u_timer (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .load    (timer_load),
    .stretch (cfg[`CSX_AX_STRETCH]),
    .expired (timer_expired)
  );

  assign parity = ^main_working_register;

  // Register file
  always_comb begin
    next_program_status_word = program_status_word;
    next_aux_memory_control  = aux_memory_control;
    next_aux_control_second  = aux_control_second;
    next_sfr_rdata           = sfr_rdata;
    if (sfr_wr) begin
      case (sfr_addr)
        `CSX_STATUS_ADDR:     next_program_status_word = sfr_wdata;
        `CSX_AUX_MEM_ADDR:    next_aux_memory_control = {1'b0, sfr_wdata[6:0]};
        `CSX_AUX_SECOND_ADDR: next_aux_control_second = {7'h00, sfr_wdata[`CSX_A2_PTR_SEL]};
        default:              next_sfr_rdata = sfr_rdata;
      endcase
    end
    // Hardware overflow update wins over a same-cycle write
    if (ovf_update) begin
      next_program_status_word[`CSX_ST_OVERFLOW] = ovf_value;
    end
    next_program_status_word[`CSX_ST_PARITY] = parity;
    if (sfr_rd) begin
      case (sfr_addr)
        `CSX_STATUS_ADDR:     next_sfr_rdata = {program_status_word[7:1], parity};
        `CSX_AUX_MEM_ADDR:    next_sfr_rdata = aux_memory_control;
        `CSX_AUX_SECOND_ADDR: next_sfr_rdata = aux_control_second;
        default:              next_sfr_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      program_status_word <= `CSX_STATUS_RESET;
      aux_memory_control  <= `CSX_AUX_MEM_RESET;
      aux_control_second  <= `CSX_AUX_SECOND_RESET;
      sfr_rdata           <= 8'h00;
    end else begin
      program_status_word <= next_program_status_word;
      aux_memory_control  <= next_aux_memory_control;
      aux_control_second  <= next_aux_control_second;
      sfr_rdata           <= next_sfr_rdata;
    end
  end

  // Expanded RAM top address per size code
  always_comb begin
    case (cfg[`CSX_AX_SIZE_HI:`CSX_AX_SIZE_LO])
      2'b00:   size_limit = 16'h00FF;
      2'b01:   size_limit = 16'h01FF;
      2'b10:   size_limit = 16'h03FF;
      default: size_limit = 16'h07FF;
    endcase
  end

  // External bus sequencer; config bits 6 to 1 are captured per move so mid-cycle writes cannot disturb them, latch gate bit 0 is read live
  always_comb begin
    next_state          = state;
    next_cfg            = cfg;
    next_cyc_write      = cyc_write;
    next_cyc_ptr        = cyc_ptr;
    next_cyc_addr       = cyc_addr;
    next_move_busy      = move_busy;
    next_move_done      = 1'b0;
    next_onchip_sel     = onchip_sel;
    next_port_two       = port_two;
    next_addr_low       = addr_low;
    next_rd_strobe_n    = 1'b1;
    next_wr_strobe_n    = 1'b1;
    next_latch_strobe   = 1'b0;
    timer_load          = 1'b0;
    next_latch_div      = (latch_div == `CSX_LATCH_PERIOD - 2'd1) ? 2'd0 : latch_div + 2'd1;
    next_bank_base      = 5'(program_status_word[`CSX_ST_BANK_HI:`CSX_ST_BANK_LO]) * `CSX_BANK_STRIDE;
    next_pointer_select = aux_control_second[`CSX_A2_PTR_SEL];
    next_wide_mode      = cfg[`CSX_AX_WIDE];
    if (!aux_memory_control[`CSX_AX_LATCH_GATE]) begin
      next_latch_strobe = (latch_div == 2'd0);
    end
    case (state)
      CSX_IDLE: begin
        if (move_req) begin
          next_cfg       = aux_memory_control;
          next_cyc_write = move_write;
          next_cyc_ptr   = move_via_pointer;
          next_cyc_addr  = move_via_pointer ? move_addr : {8'h00, move_addr[7:0]};
          next_move_busy = 1'b1;
          next_state     = CSX_ADDR;
        end
      end
      CSX_ADDR: begin
        // Off-chip when routed out or above the sized window
        if (cfg[`CSX_AX_EXT_ROUTE] || (cyc_addr > size_limit)) begin
          next_onchip_sel   = 1'b0;
          next_addr_low     = cyc_addr[7:0];
          next_latch_strobe = 1'b1;
          if (cyc_ptr && !cfg[`CSX_AX_HIGH_DIS]) begin
            next_port_two = cyc_addr[15:8];
          end else begin
            next_port_two = port_two_latch;
          end
          timer_load = 1'b1;
          next_state = CSX_STROBE;
        end else begin
          next_onchip_sel = 1'b1;
          next_state      = CSX_DONE;
        end
      end
      CSX_STROBE: begin
        next_rd_strobe_n = cyc_write;
        next_wr_strobe_n = !cyc_write;
        if (timer_expired) begin
          next_state = CSX_DONE;
        end
      end
      CSX_DONE: begin
        next_move_busy = 1'b0;
        next_move_done = 1'b1;
        next_port_two  = port_two_latch;
        next_state     = CSX_IDLE;
      end
      default: next_state = CSX_IDLE;
    endcase
    if (state == CSX_IDLE && !move_req) begin
      next_port_two = port_two_latch;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state          <= CSX_IDLE;
      cfg            <= `CSX_AUX_MEM_RESET;
      cyc_write      <= 1'b0;
      cyc_ptr        <= 1'b0;
      cyc_addr       <= 16'h0000;
      latch_div      <= 2'd0;
      move_busy      <= 1'b0;
      move_done      <= 1'b0;
      bank_base      <= 5'h00;
      pointer_select <= 1'b0;
      onchip_sel     <= 1'b1;
      wide_mode      <= 1'b0;
      port_two       <= 8'hFF;
      addr_low       <= 8'h00;
      latch_strobe   <= 1'b0;
      rd_strobe_n    <= 1'b1;
      wr_strobe_n    <= 1'b1;
    end else begin
      state          <= next_state;
      cfg            <= next_cfg;
      cyc_write      <= next_cyc_write;
      cyc_ptr        <= next_cyc_ptr;
      cyc_addr       <= next_cyc_addr;
      latch_div      <= next_latch_div;
      move_busy      <= next_move_busy;
      move_done      <= next_move_done;
      bank_base      <= next_bank_base;
      pointer_select <= next_pointer_select;
      onchip_sel     <= next_onchip_sel;
      wide_mode      <= next_wide_mode;
      port_two       <= next_port_two;
      addr_low       <= next_addr_low;
      latch_strobe   <= next_latch_strobe;
      rd_strobe_n    <= next_rd_strobe_n;
      wr_strobe_n    <= next_wr_strobe_n;
    end
  end
endmodule

/* csx_core_status_props.sv */
// Concurrent checks on the core status block ports
`timescale 1ns/100ps
module csx_core_status_props (
  // Clock and reset
  input wire logic               ref_clk,
  input wire logic               arst_n,
  // Register port
  input wire logic               sfr_rd,
  input wire csx_pkg::csx_byte_t sfr_addr,
  input wire csx_pkg::csx_byte_t sfr_rdata,
  input wire csx_pkg::csx_byte_t main_working_register,
  // Move and pins
  input wire logic               move_req,
  input wire logic               move_busy,
  input wire logic               move_done,
  input wire logic [4:0]         bank_base,
  input wire logic               latch_strobe,
  input wire logic               rd_strobe_n,
  input wire logic               wr_strobe_n
);
  import csx_pkg::*;
  logic [4:0] low_cnt;
  logic [4:0] next_low_cnt;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  // Length of the current strobe, cleared once it has been judged
  always_comb begin
    next_low_cnt = (!rd_strobe_n || !wr_strobe_n) ? low_cnt + 5'h01 : 5'h00;
  end
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n)
      low_cnt <= 5'h00;
    else
      low_cnt <= next_low_cnt;
  end
  parity_read_a: assert property (sfr_rd && sfr_addr == 8'hD0 |=>
    sfr_rdata[0] == ^$past(main_working_register)) else $error("parity bit wrong");
  bank_match_a: assert property (sfr_rd && sfr_addr == 8'hD0 |=>
    bank_base == {sfr_rdata[4:3], 3'h0}) else $error("bank base wrong");
  unmapped_zero_a: assert property (sfr_rd && !(sfr_addr inside {8'hD0, 8'h8E, 8'hA2}) |=>
    sfr_rdata == 8'h00) else $error("unmapped read not zero");
  strobe_width_a: assert property (rd_strobe_n && wr_strobe_n && low_cnt != 5'h00 |->
    low_cnt == 5'd3 || low_cnt == 5'd15) else $error("strobe width wrong");
  strobe_excl_a: assert property (!(!rd_strobe_n && !wr_strobe_n)) else $error("both strobes low");
  latch_lead_a: assert property ($fell(rd_strobe_n) || $fell(wr_strobe_n) |->
    $past(latch_strobe)) else $error("no latch pulse before strobe");
  req_busy_a: assert property (move_req && !move_busy |=> move_busy) else $error("move not taken");
  done_end_a: assert property (move_done |-> $past(move_busy) && !move_busy) else $error("done misplaced");
  idle_strobe_a: assert property (!move_busy |-> rd_strobe_n && wr_strobe_n) else $error("strobe while idle");
endmodule
bind csx_core_status csx_core_status_props u_csx_core_status_props (.ref_clk, .arst_n, .sfr_rd, .sfr_addr,
  .sfr_rdata, .main_working_register, .move_req, .move_busy, .move_done, .bank_base, .latch_strobe,
  .rd_strobe_n, .wr_strobe_n);

/* csx_core_status_tb.sv */
// Self-checking bench for the core status block
`timescale 1ns/100ps
module csx_core_status_tb;
  import csx_pkg::*;
  typedef struct packed {csx_byte_t a; csx_byte_t w; csx_byte_t acc; csx_byte_t e;} csx_row_t;
  logic        ref_clk, arst_n, sfr_wr, sfr_rd, ovf_update, ovf_value, move_req, move_write, move_via_pointer;
  csx_byte_t   sfr_addr, sfr_wdata, sfr_rdata, main_working_register, port_two_latch, port_two, addr_low, hi_seen, d;
  logic [15:0] move_addr;
  logic        move_busy, move_done, pointer_select, onchip_sel, wide_mode, latch_strobe, rd_strobe_n, wr_strobe_n;
  logic [4:0]  bank_base;
  logic [3:0]  width;
  int          num_errors, total_checks, n;
  // Bit 7 of the auxiliary register is never written as one
  csx_row_t rows [6] = '{'{8'hD0, 8'hFE, 8'h01, 8'hFF}, '{8'hD0, 8'h18, 8'h03, 8'h18}, '{8'h8E, 8'h3A, 8'h00, 8'h3A},
    '{8'hA2, 8'hFF, 8'h00, 8'h01}, '{8'h55, 8'hFF, 8'h00, 8'h00}, '{8'h8E, 8'h0D, 8'h07, 8'h0D}};
  csx_core_status u_csx_core_status (.ref_clk, .arst_n, .sfr_wr, .sfr_rd, .sfr_addr, .sfr_wdata, .sfr_rdata,
    .main_working_register, .ovf_update, .ovf_value, .move_req, .move_write, .move_via_pointer, .move_addr,
    .port_two_latch, .move_busy, .move_done, .bank_base, .pointer_select, .onchip_sel, .wide_mode, .port_two,
    .addr_low, .latch_strobe, .rd_strobe_n, .wr_strobe_n);
  csx_xmem_model u_csx_xmem_model (.ref_clk, .arst_n, .rd_strobe_n, .wr_strobe_n, .port_two, .width, .hi_seen);
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (exp !== got) begin
      $display("wrong value %s expected %h seen %h", name, exp, got);
      num_errors++;
    end
  endtask
  task automatic sfr_write(input csx_byte_t a, input csx_byte_t w);
    @(negedge ref_clk);
    sfr_wr = 1'b1;
    sfr_addr = a;
    sfr_wdata = w;
    @(negedge ref_clk);
    sfr_wr = 1'b0;
  endtask
  task automatic sfr_read(input csx_byte_t a);
    @(negedge ref_clk);
    sfr_rd = 1'b1;
    sfr_addr = a;
    @(negedge ref_clk);
    sfr_rd = 1'b0;
    d = sfr_rdata;
  endtask
  // Optional register write while the move is running
  task automatic move(input logic w, input logic p, input logic [15:0] a, input logic mid);
    @(negedge ref_clk);
    move_req = 1'b1;
    move_write = w;
    move_via_pointer = p;
    move_addr = a;
    @(negedge ref_clk);
    move_req = 1'b0;
    if (mid)
      sfr_write(8'h8E, 8'h0D);
    n = 0;
    while (move_done !== 1'b1 && n < 60) begin
      @(negedge ref_clk);
      n++;
    end
    if (move_done !== 1'b1) begin
      num_errors++;
      wrap_up();
    end
    // One more clock so the memory model has closed its strobe count
    @(negedge ref_clk);
  endtask
  task automatic latch_count(input int exp);
    n = 0;
    repeat (9) begin
      @(negedge ref_clk);
      n += int'(latch_strobe);
    end
    check("latch pulses", exp[7:0], n[7:0]);
  endtask
  initial begin
    {arst_n, sfr_wr, sfr_rd, ovf_update, ovf_value, move_req, move_write, move_via_pointer} = 8'h00;
    {sfr_addr, sfr_wdata, main_working_register, move_addr} = 40'h0;
    port_two_latch = 8'hA5;
    repeat (4) @(negedge ref_clk);
    check("idle port", 8'hFF, port_two);
    arst_n = 1'b1;
    sfr_read(8'h8E);
    check("aux reset", 8'h0D, d);
    sfr_read(8'hD0);
    check("status reset", 8'h00, d);
    $display("reset test done");
    foreach (rows[i]) begin
      main_working_register = rows[i].acc;
      sfr_write(rows[i].a, rows[i].w);
      sfr_read(rows[i].a);
      check("readback", rows[i].e, d);
    end
    check("pointer select", 8'h01, {7'h0, pointer_select});
    for (int k = 0; k < 4; k++) begin
      sfr_write(8'hD0, 8'(k << 3));
      @(negedge ref_clk);
      check("bank base", 8'(k * 8), {3'h0, bank_base});
    end
    @(negedge ref_clk);
    ovf_update = 1'b1;
    ovf_value = 1'b1;
    @(negedge ref_clk);
    ovf_update = 1'b0;
    sfr_read(8'hD0);
    check("overflow", 8'h01, {7'h0, d[2]});
    $display("status tests done");
    for (int k = 0; k < 4; k++) begin
      sfr_write(8'h8E, 8'(k << 2) | 8'h01);
      move(1'b0, 1'b1, (16'h0100 << k) - 16'h1, 1'b0);
      check("on-chip", 8'h01, {7'h0, onchip_sel});
      move(1'b0, 1'b1, 16'h0100 << k, 1'b0);
      check("off-chip", 8'h00, {7'h0, onchip_sel});
      check("width", 8'h03, {4'h0, width});
    end
    sfr_write(8'h8E, 8'h0F);
    move(1'b1, 1'b0, 16'h0000, 1'b0);
    check("routed", 8'h00, {7'h0, onchip_sel});
    sfr_write(8'h8E, 8'h6F);
    move(1'b1, 1'b1, 16'h0000, 1'b1);
    check("stretched", 8'h0F, {4'h0, width});
    check("wide", 8'h01, {7'h0, wide_mode});
    move(1'b0, 1'b1, 16'h1234, 1'b0);
    check("short", 8'h03, {4'h0, width});
    check("narrow", 8'h00, {7'h0, wide_mode});
    check("high byte", 8'h12, hi_seen);
    check("low address", 8'h34, addr_low);
    // Indirect moves stay on-chip unless routed out
    sfr_write(8'h8E, 8'h0F);
    move(1'b0, 1'b0, 16'h1234, 1'b0);
    check("port byte", 8'hA5, hi_seen);
    sfr_write(8'h8E, 8'h1D);
    move(1'b1, 1'b1, 16'h1234, 1'b0);
    check("suppressed", 8'hA5, hi_seen);
    $display("move tests done");
    latch_count(0);
    sfr_write(8'h8E, 8'h0C);
    latch_count(3);
    $display("latch tests done");
    // Reset in the middle of a stretched off-chip write
    sfr_write(8'h8E, 8'h2F);
    @(negedge ref_clk);
    move_req = 1'b1;
    @(negedge ref_clk);
    move_req = 1'b0;
    repeat (5) @(negedge ref_clk);
    check("strobe before reset", 8'h00, {7'h0, wr_strobe_n});
    arst_n = 1'b0;
    @(negedge ref_clk);
    check("strobes in reset", 8'h03, {6'h0, rd_strobe_n, wr_strobe_n});
    check("busy in reset", 8'h00, {7'h0, move_busy});
    arst_n = 1'b1;
    sfr_read(8'h8E);
    check("aux after reset", 8'h0D, d);
    sfr_read(8'hD0);
    check("status after reset", 8'h01, d);
    $display("mid reset test done");
    wrap_up();
  end
endmodule

/* csx_map.svh */
// Register offsets, field positions, reset values and timing counts for the core status block
`ifndef CSX_MAP_SVH
`define CSX_MAP_SVH
`define CSX_AUX_MEM_ADDR      8'h8E
`define CSX_AUX_SECOND_ADDR   8'hA2
`define CSX_STATUS_ADDR       8'hD0
`define CSX_AUX_MEM_RESET     8'h0D
`define CSX_STATUS_RESET      8'h00
`define CSX_AUX_SECOND_RESET  8'h00
`define CSX_ST_PARITY         0
`define CSX_ST_FLAG_B         1
`define CSX_ST_OVERFLOW       2
`define CSX_ST_BANK_LO        3
`define CSX_ST_BANK_HI        4
`define CSX_ST_FLAG_A         5
`define CSX_AX_LATCH_GATE     0
`define CSX_AX_EXT_ROUTE      1
`define CSX_AX_SIZE_LO        2
`define CSX_AX_SIZE_HI        3
`define CSX_AX_HIGH_DIS       4
`define CSX_AX_STRETCH        5
`define CSX_AX_WIDE           6
`define CSX_A2_PTR_SEL        0
`define CSX_STROBE_SHORT      4'd3
`define CSX_STROBE_LONG       4'd15
`define CSX_LATCH_PERIOD      2'd3
`define CSX_BANK_STRIDE       5'h08
`endif

/* csx_pkg.sv */
// Types shared by the core status block
package csx_pkg;
  typedef enum logic [1:0] {CSX_IDLE, CSX_ADDR, CSX_STROBE, CSX_DONE} csx_bus_state_t;
  typedef logic [7:0] csx_byte_t;
endpackage

/* csx_strobe_timer.sv */
// Down counter timing the width of one external read or write strobe
`timescale 1ns/100ps
`include "csx_map.svh"
module csx_strobe_timer (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       arst_n,
  // Control
  input  wire logic       load,
  input  wire logic       stretch,
  // Status
  output logic            expired
);
  logic [3:0] count;
  logic [3:0] next_count;

  always_comb begin
    next_count = count;
    if (load) begin
      next_count = stretch ? `CSX_STROBE_LONG : `CSX_STROBE_SHORT;
    end else if (count != 4'h0) begin
      next_count = count - 4'h1;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      count <= 4'h0;
    end else begin
      count <= next_count;
    end
  end

  // Last strobe cycle when the count reaches one
  assign expired = (count == 4'h1) && !load;
endmodule

/* csx_xmem_model.sv */
// External memory model measuring strobe width and the high address byte
`timescale 1ns/100ps
module csx_xmem_model (
  // Clock and reset
  input  wire logic               ref_clk,
  input  wire logic               arst_n,
  // Bus pins
  input  wire logic               rd_strobe_n,
  input  wire logic               wr_strobe_n,
  input  wire csx_pkg::csx_byte_t port_two,
  // Observations
  output logic [3:0]              width,
  output csx_pkg::csx_byte_t      hi_seen
);
  import csx_pkg::*;
  logic [3:0] cnt;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= 4'h0;
      width <= 4'h0;
      hi_seen <= 8'h00;
    end else if (!rd_strobe_n || !wr_strobe_n) begin
      cnt <= cnt + 4'h1;
      if (cnt == 4'h0)
        hi_seen <= port_two;
    end else if (cnt != 4'h0) begin
      width <= cnt;
      cnt <= 4'h0;
    end
  end
endmodule
